// [hdl/ivl_ctrl.sv]
// Interrupt recognition, vector fetch and wait/stop control with APB registers.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "ivl_defs.svh"
module ivl_ctrl
  import ivl_pkg::*;
#(
  parameter int NSRC  = 18,
  parameter int NSLOT = 16
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Peripheral event pulses
  input  wire logic [NSRC-1:0] src_event_i,
  // External request pins, active low
  input  wire logic        irq_pin_n_i,
  input  wire logic        nonmaskable_pin_n_i,
  // CPU core
  input  wire logic        insn_boundary_i,
  input  wire logic        soft_trap_i,
  input  wire logic        halt_opcode_i,
  input  wire logic        stop_opcode_i,
  input  wire logic        flag_i_i,
  input  wire logic        flag_x_i,
  input  wire logic [15:0] stack_ptr_i,
  output logic             cpu_run_o,
  output logic             set_i_mask_o,
  output logic             set_x_mask_o,
  output logic      [3:0]  stack_sel_o,
  output logic             vector_load_o,
  output logic      [15:0] handler_addr_o,
  // Memory bus
  output logic      [15:0] bus_addr_o,
  output logic             bus_rd_o,
  output logic             bus_wr_o,
  input  wire logic [7:0]  bus_rdata_i,
  // Power and clocks
  output logic             timer_halt_o,
  output logic             clocks_run_o,
  output logic             osc_run_o,
  output logic             clock_fail_monitor_enable_o
);

  generate
    if (NSRC != 18 || NSLOT != 16)
    begin : g_bad
      $error("ivl_ctrl: source and slot counts are fixed by the vector table");
    end
  endgenerate

  function automatic logic [15:0] vec_of(input logic [4:0] s);
    return `IVL_VEC_BASE + {10'h000, s, 1'b0};
  endfunction

  // -----------------------------------------------------------------------
  // Registers and pin inputs
  // -----------------------------------------------------------------------
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] enables;
  logic [7:0]      syscfg_opts;
  logic            watchdog_disable;
  logic [1:0]      pin_sync;
  ivl_state_e      state;
  ivl_state_e      next_state;
  ivl_mode_e       mode;
  ivl_mode_e       next_mode;
  logic [3:0]      cnt;
  logic [3:0]      next_cnt;
  logic [11:0]     settle;
  logic [11:0]     next_settle;
  logic [4:0]      slot;
  logic [4:0]      next_slot;
  logic [15:0]     sp;
  logic [7:0]      vec_hi;

  ivl_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({nonmaskable_pin_n_i, irq_pin_n_i}),
    .sync_o     (pin_sync)
  );

  wire ext_pin_level = ~pin_sync[0];
  wire nmi_level     = ~pin_sync[1];
  wire stop_exit_delay_enable = syscfg_opts[`IVL_OPT_DELAY_BIT];

  // -----------------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------------
  wire apb_wr     = psel_i & penable_i & pwrite_i;
  wire hit_flags  = (paddr_i == `IVL_OFS_FLAGS);
  wire hit_enab   = (paddr_i == `IVL_OFS_ENABLES);
  wire hit_opts   = (paddr_i == `IVL_OFS_SYSCFG_OPTS);
  wire hit_ctrl   = (paddr_i == `IVL_OFS_CONTROL);
  wire hit_status = (paddr_i == `IVL_OFS_STATUS);
  wire hit_any    = hit_flags | hit_enab | hit_opts | hit_ctrl | hit_status;
  wire [NSRC-1:0] flag_clr = (apb_wr && hit_flags) ? pwdata_i[NSRC-1:0] : '0;

  // -----------------------------------------------------------------------
  // Source gating and priority
  // -----------------------------------------------------------------------
  wire [NSRC-1:0]  live = flags & enables;
  logic [NSLOT-1:0] slot_req;
  logic            any_req;
  logic [4:0]      prio_idx;

  assign slot_req[0] = (|live[`IVL_SERIAL_SRC_CNT-1:0]) & ~flag_i_i;

  genvar k;
  generate
    for (k = 1; k < 14; k++)
    begin : g_slot
      assign slot_req[k] = live[k+`IVL_SERIAL_SRC_CNT-1] & ~flag_i_i;
    end
  endgenerate

  assign slot_req[14] = ext_pin_level & ~flag_i_i;
  assign slot_req[15] = nmi_level & ~flag_x_i;

  ivl_prio #(
    .N  (NSLOT),
    .IW (5)
  ) u_prio (
    .req_i (slot_req),
    .any_o (any_req),
    .idx_o (prio_idx)
  );

  // -----------------------------------------------------------------------
  // Register file
  // -----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flags            <= `IVL_FLAGS_RST;
      enables          <= `IVL_ENABLES_RST;
      syscfg_opts      <= `IVL_OPTS_RST;
      watchdog_disable <= `IVL_CTRL_RST;
    end
    else
    begin
      flags <= (flags & ~flag_clr) | src_event_i;
      if (apb_wr && hit_enab)
        enables <= pwdata_i[NSRC-1:0];
      if (apb_wr && hit_opts)
        syscfg_opts <= pwdata_i[7:0] & `IVL_OPTS_WMASK;
      if (apb_wr && hit_ctrl)
        watchdog_disable <= pwdata_i[`IVL_CTRL_WDDIS_BIT];
    end
  end

  wire [31:0] status_word = {20'h00000, ext_pin_level, nmi_level, timer_halt_o,
                             any_req, prio_idx, state};

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit_any;
  assign prdata_o  = hit_flags  ? {14'h0000, flags} :
                     hit_enab   ? {14'h0000, enables} :
                     hit_opts   ? {24'h000000, syscfg_opts} :
                     hit_ctrl   ? {31'h00000000, watchdog_disable} :
                     hit_status ? status_word : 32'h00000000;

  // -----------------------------------------------------------------------
  // Service sequencer
  // -----------------------------------------------------------------------
  always_comb
  begin
    next_state  = state;
    next_mode   = mode;
    next_cnt    = cnt;
    next_settle = settle;
    next_slot   = slot;
    case (state)
      IVL_ST_RUN:
      begin
        if (insn_boundary_i)
        begin
          if (soft_trap_i)
          begin
            next_state = IVL_ST_STACK;
            next_mode  = IVL_MODE_TRAP;
            next_cnt   = 4'h0;
          end
          else if (halt_opcode_i)
          begin
            next_state = IVL_ST_STACK;
            next_mode  = IVL_MODE_HALT;
            next_cnt   = 4'h0;
          end
          else if (stop_opcode_i)
            next_state = IVL_ST_STOP;
          else if (any_req)
          begin
            next_state = IVL_ST_STACK;
            next_mode  = IVL_MODE_SERVE;
            next_cnt   = 4'h0;
          end
        end
      end
      IVL_ST_STACK:
      begin
        if (cnt == `IVL_STACK_LAST)
        begin
          next_state = (mode == IVL_MODE_HALT) ? IVL_ST_HALT : IVL_ST_VHI;
          next_slot  = (mode == IVL_MODE_TRAP) ? `IVL_SLOT_TRAP : prio_idx;
        end
        else
          next_cnt = cnt + 4'h1;
      end
      IVL_ST_HALT:
      begin
        if (any_req)
        begin
          next_state = IVL_ST_VHI;
          next_slot  = prio_idx;
        end
      end
      IVL_ST_VHI:
        next_state = IVL_ST_VLO;
      IVL_ST_VLO:
        next_state = IVL_ST_LOAD;
      IVL_ST_LOAD:
        next_state = IVL_ST_RUN;
      IVL_ST_STOP:
      begin
        if (any_req)
        begin
          next_state  = IVL_ST_SETTLE;
          next_settle = (stop_exit_delay_enable ? `IVL_SETTLE_LONG_CYC
                                                : `IVL_SETTLE_SHORT_CYC) - 12'h001;
        end
      end
      IVL_ST_SETTLE:
      begin
        if (settle == 12'h000)
          next_state = IVL_ST_RUN;
        else
          next_settle = settle - 12'h001;
      end
      default:
        next_state = IVL_ST_RUN;
    endcase
  end

  wire enter_vector = (next_state == IVL_ST_VHI) && (state != IVL_ST_VHI);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state  <= IVL_ST_RUN;
      mode   <= IVL_MODE_SERVE;
      cnt    <= 4'h0;
      settle <= 12'h000;
      slot   <= 5'h00;
    end
    else
    begin
      state  <= next_state;
      mode   <= next_mode;
      cnt    <= next_cnt;
      settle <= next_settle;
      slot   <= next_slot;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sp             <= 16'h0000;
      vec_hi         <= 8'h00;
      handler_addr_o <= 16'h0000;
      vector_load_o  <= 1'b0;
      set_i_mask_o   <= 1'b0;
      set_x_mask_o   <= 1'b0;
    end
    else
    begin
      if (state == IVL_ST_RUN && next_state == IVL_ST_STACK)
        sp <= stack_ptr_i;
      if (state == IVL_ST_VHI)
        vec_hi <= bus_rdata_i;
      if (state == IVL_ST_VLO)
        handler_addr_o <= {vec_hi, bus_rdata_i};
      vector_load_o <= (state == IVL_ST_VLO);
      set_i_mask_o <= enter_vector;
      set_x_mask_o <= enter_vector & nmi_level & ~flag_x_i;
    end
  end

  // -----------------------------------------------------------------------
  // Bus and power outputs
  // -----------------------------------------------------------------------
  // Push sequence, halted flags reread and vector reads
  assign bus_wr_o    = (state == IVL_ST_STACK);
  assign stack_sel_o = (state == IVL_ST_STACK) ? cnt : 4'h0;
  assign bus_rd_o    = (state == IVL_ST_HALT) || (state == IVL_ST_VHI) ||
                       (state == IVL_ST_VLO);
  assign bus_addr_o  = (state == IVL_ST_STACK) ? sp - {12'h000, cnt} :
                       (state == IVL_ST_HALT)  ? sp - `IVL_FLAGS_REG_DEPTH :
                       (state == IVL_ST_VHI)   ? vec_of(slot) :
                       (state == IVL_ST_VLO)   ? vec_of(slot) + 16'h0001 : 16'h0000;

  assign cpu_run_o = (state == IVL_ST_RUN);
  assign timer_halt_o = (state == IVL_ST_HALT) & flag_i_i & watchdog_disable;
  assign clocks_run_o = (state != IVL_ST_STOP) && (state != IVL_ST_SETTLE);
  assign osc_run_o = (state != IVL_ST_STOP);
  assign clock_fail_monitor_enable_o = syscfg_opts[`IVL_OPT_CLKMON_BIT];

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_vector_pair;
    (bus_rd_o && bus_addr_o == vec_of(slot)) ##1
    (bus_rd_o && bus_addr_o == vec_of(slot) + 16'h0001) ##1 vector_load_o;
  endsequence

  sequence s_trap_start;
    state == IVL_ST_RUN && insn_boundary_i && soft_trap_i;
  endsequence

  a_mid_insn_hold: assert property (
    (state == IVL_ST_RUN && !insn_boundary_i) |=> state == IVL_ST_RUN)
    else $error("service began inside an instruction");

  a_mask_after_stack: assert property (
    (state == IVL_ST_STACK && cnt == `IVL_STACK_LAST && mode != IVL_MODE_HALT)
    |=> set_i_mask_o && state == IVL_ST_VHI)
    else $error("I mask not set right after flags register stacked");

  a_vector_fetch: assert property (
    (state == IVL_ST_VHI) |-> s_vector_pair)
    else $error("vector pair not read high then low");

  a_trap_vector: assert property (
    s_trap_start |=> (state == IVL_ST_STACK)[*8] ##1 state == IVL_ST_STACK ##1
    (state == IVL_ST_VHI && slot == `IVL_SLOT_TRAP))
    else $error("soft trap did not stack nine bytes and vector");

  a_halt_reads: assert property (
    (state == IVL_ST_HALT) |-> bus_rd_o && bus_addr_o == sp - 16'h0008)
    else $error("halted bus not rereading stacked flags");

  a_halt_exit: assert property (
    (state == IVL_ST_HALT && any_req) |=> state == IVL_ST_VHI && slot == $past(prio_idx))
    else $error("unmasked interrupt did not end halted state");

  a_timer_runs: assert property (
    (state == IVL_ST_HALT && (!flag_i_i || !watchdog_disable)) |-> !timer_halt_o)
    else $error("timer stopped while it should run");

  a_short_settle: assert property (
    (state == IVL_ST_STOP && any_req && !stop_exit_delay_enable) |=>
    (state == IVL_ST_SETTLE)[*4] ##1 state == IVL_ST_RUN)
    else $error("short stop exit not four cycles");

  a_osc_in_halt: assert property (
    (state == IVL_ST_HALT) |-> osc_run_o && !clocks_run_o == 1'b0)
    else $error("oscillator off during halted state");

  a_flag_set_wins: assert property (
    (src_event_i[0] && flag_clr[0]) |=> flags[0])
    else $error("event lost against a clear");

  a_masked_no_serve: assert property (
    (state == IVL_ST_RUN && insn_boundary_i && flag_i_i && flag_x_i &&
     !soft_trap_i && !halt_opcode_i && !stop_opcode_i) |=> state == IVL_ST_RUN)
    else $error("masked source was served");

endmodule

// [hdl/ivl_defs.svh]
// Constants for the interrupt vector and low-power controller.
`ifndef IVL_DEFS_SVH
`define IVL_DEFS_SVH

// -------------------------------------------------------------------------
// Register offsets (byte addresses)
// -------------------------------------------------------------------------
`define IVL_OFS_FLAGS        8'h00
`define IVL_OFS_ENABLES      8'h04
`define IVL_OFS_SYSCFG_OPTS  8'h08
`define IVL_OFS_CONTROL      8'h0C
`define IVL_OFS_STATUS       8'h10

// -------------------------------------------------------------------------
// Reset values and field positions
// -------------------------------------------------------------------------
`define IVL_FLAGS_RST        18'h00000
`define IVL_ENABLES_RST      18'h00000
`define IVL_OPTS_RST         8'h10
`define IVL_OPTS_WMASK       8'hFB
`define IVL_OPT_DELAY_BIT    4
`define IVL_OPT_CLKMON_BIT   3
`define IVL_CTRL_WDDIS_BIT   0
`define IVL_CTRL_RST         1'h0
`define IVL_SERIAL_SRC_CNT   5

// -------------------------------------------------------------------------
// Vectors and slots
// -------------------------------------------------------------------------
`define IVL_VEC_BASE         16'hFFD6
`define IVL_SLOT_EXT_PIN     5'h0E
`define IVL_SLOT_NMI_PIN     5'h0F
`define IVL_SLOT_TRAP        5'h10
`define IVL_STACK_LAST       4'h8
`define IVL_FLAGS_REG_DEPTH  16'h0008

// -------------------------------------------------------------------------
// Timing counts in clock cycles
// -------------------------------------------------------------------------
`define IVL_SETTLE_LONG_CYC  12'hFA0
`define IVL_SETTLE_SHORT_CYC 12'h004

`endif

// [hdl/ivl_pkg.sv]
// Types shared by the interrupt vector and low-power controller.
package ivl_pkg;

  typedef enum logic [2:0] {
    IVL_ST_RUN    = 3'h0,
    IVL_ST_STACK  = 3'h1,
    IVL_ST_HALT   = 3'h2,
    IVL_ST_VHI    = 3'h3,
    IVL_ST_VLO    = 3'h4,
    IVL_ST_LOAD   = 3'h5,
    IVL_ST_STOP   = 3'h6,
    IVL_ST_SETTLE = 3'h7
  } ivl_state_e;

  typedef enum logic [1:0] {
    IVL_MODE_SERVE = 2'h0,
    IVL_MODE_TRAP  = 2'h1,
    IVL_MODE_HALT  = 2'h2
  } ivl_mode_e;

endpackage

// [hdl/ivl_sync.sv]
// Two-flop synchroniser for asynchronous pin levels.
`timescale 1ns/1ns
module ivl_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta   <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// [hdl/ivl_prio.sv]
// Fixed-priority encoder: the highest set index wins.
`timescale 1ns/1ns
module ivl_prio #(
  parameter int N  = 16,
  parameter int IW = 5
) (
  // Requests
  input  wire logic [N-1:0]  req_i,
  // Winner
  output logic               any_o,
  output logic      [IW-1:0] idx_o
);

  generate
    if (N < 2 || (1 << IW) < N)
    begin : g_bad
      $error("ivl_prio: index width too small for request count");
    end
  endgenerate

  // Later indices overwrite earlier ones, so the top index wins.
  // Higher slot wins
  always_comb
  begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = 0; i < N; i++)
    begin
      if (req_i[i])
      begin
        any_o = 1'b1;
        idx_o = IW'(i);
      end
    end
  end

endmodule

// [verification/ivl_mem_model.sv]
// Memory partner model that answers the controller's vector reads.
`timescale 1ns/1ns
module ivl_mem_model (
  // Clock
  input  wire logic        core_clk_i,
  // Memory bus
  input  wire logic [15:0] bus_addr_i,
  input  wire logic        bus_rd_i,
  output logic      [7:0]  bus_rdata_o
);
  logic [7:0] junk = 8'h5A;

  // Data lines change every cycle when nobody reads, so stale data is never mistaken.
  always @(posedge core_clk_i)
  begin
    junk <= junk + 8'h35;
  end

  assign bus_rdata_o = !bus_rd_i ? junk : (bus_addr_i[0] ? ~bus_addr_i[7:0] : bus_addr_i[7:0]);
endmodule

// [verification/interrupt_vector_lowpower_tb.sv]
// Self-checking bench for the interrupt vector and low-power controller.
`timescale 1ns/1ns
module interrupt_vector_lowpower_tb;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0]  paddr = 8'h00, brdata;
  logic [31:0] pwdata = 32'h0, prdata, lf = 32'h03AA;
  logic [17:0] src_ev = 18'h0;
  logic        irq_n = 1'b1, nmi_n = 1'b1, bnd = 1'b0, trap = 1'b0, hlt = 1'b0;
  logic        stp = 1'b0, fi = 1'b0, fx = 1'b0, run, seti, setx, vld, brd, bwr;
  logic        thalt, crun, orun, cfm, saw_i = 1'b0, saw_x = 1'b0;
  logic [3:0]  ssel;
  logic [15:0] sp = 16'h01FF, haddr, baddr;
  logic [32:0] q_rd[$];
  logic [15:0] q_vec[$];
  int          n_errors = 0, tests_run = 0;
  int          n_push = 0;

  always #25 clk = ~clk;

  ivl_ctrl dut (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .src_event_i(src_ev), .irq_pin_n_i(irq_n),
    .nonmaskable_pin_n_i(nmi_n), .insn_boundary_i(bnd), .soft_trap_i(trap),
    .halt_opcode_i(hlt), .stop_opcode_i(stp), .flag_i_i(fi), .flag_x_i(fx),
    .stack_ptr_i(sp), .cpu_run_o(run), .set_i_mask_o(seti), .set_x_mask_o(setx),
    .stack_sel_o(ssel), .vector_load_o(vld), .handler_addr_o(haddr), .bus_addr_o(baddr),
    .bus_rd_o(brd), .bus_wr_o(bwr), .bus_rdata_i(brdata), .timer_halt_o(thalt),
    .clocks_run_o(crun), .osc_run_o(orun), .clock_fail_monitor_enable_o(cfm));

  ivl_mem_model mem (.core_clk_i(clk), .bus_addr_i(baddr), .bus_rd_i(brd),
    .bus_rdata_o(brdata));

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Handler address that the memory model holds for a slot.
  function logic [15:0] vexp(input int s);
    logic [7:0] a;
    a = 8'hD6 + 8'(2 * s);
    return {a, ~(a + 8'h01)};
  endfunction

  task close_out;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    chk({17'h00000, got}, {17'h00000, exp});
  endtask

  task tmo;
    n_errors++;
    close_out;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      tmo;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] exp);
    q_rd.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task pulse_ev(input int b);
    src_ev <= 18'h1 << b;
    @(posedge clk);
    src_ev <= 18'h0;
    @(posedge clk);
  endtask

  task bound(input logic [2:0] m);
    bnd  <= 1'b1;
    trap <= m[2];
    hlt  <= m[1];
    stp  <= m[0];
    @(posedge clk);
    {bnd, trap, hlt, stp} <= 4'h0;
  endtask

  task wait_q;
    int k;
    for (k = 0; k < 60 && q_vec.size() > 0; k++)
      @(posedge clk);
    if (q_vec.size() > 0)
      tmo;
  endtask

  task serve(input logic [2:0] m, input int s);
    q_vec.push_back(vexp(s));
    bound(m);
    wait_q;
    cyc(2);
  endtask

  // Read data is taken at the access edge, where pready is sampled high.
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && q_rd.size() > 0)
      chk_rd({pslverr, prdata}, q_rd.pop_front());
  end

  // A vector load with nothing expected is compared against unknown and fails.
  always @(negedge clk)
  begin
    if (bwr === 1'b1)
    begin
      chk({ssel, baddr}, {n_push[3:0], sp - 16'(n_push)});
      n_push++;
    end
    if (vld === 1'b1)
    begin
      chk(33'(n_push), 33'd9);
      n_push = 0;
      chk_vec(haddr, q_vec.size() > 0 ? q_vec.pop_front() : 16'hXXXX);
    end
    if (seti === 1'b1)
      saw_i = 1'b1;
    if (setx === 1'b1)
      saw_x = 1'b1;
  end

  // -----------------------------------------------------------------------
  // Sequence
  // -----------------------------------------------------------------------
  initial
  begin
    int k, n, b, d;
    cyc(12);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h08, 33'h10);
    rd(8'h14, 33'h100000000);
    apb(1'b1, 8'h08, 32'hFF);
    rd(8'h08, 33'hFB);
    @(negedge clk);
    chk(cfm, 33'h1);
    @(posedge clk);
    lf = lfsr(lf);
    apb(1'b1, 8'h04, lf);
    rd(8'h04, {15'h0, lf[17:0]});
    $display("test registers done");
    apb(1'b1, 8'h04, 32'h0);
    // An event and its clear meet at one edge; the event must win.
    fork
      apb(1'b1, 8'h00, 32'h1);
      begin
        @(posedge clk);
        src_ev <= 18'h1;
        @(posedge clk);
        src_ev <= 18'h0;
      end
    join
    rd(8'h00, 33'h1);
    pulse_ev(10);
    bound(3'h0);
    cyc(14);
    chk(run, 33'h1);
    apb(1'b1, 8'h04, 32'h3FFFF);
    fi <= 1'b1;
    fx <= 1'b1;
    bound(3'h0);
    cyc(14);
    chk(run, 33'h1);
    fi <= 1'b0;
    fx <= 1'b0;
    saw_i = 1'b0;
    serve(3'h0, 6);
    chk(saw_i, 33'h1);
    apb(1'b1, 8'h00, 32'h3FFFF);
    for (b = 0; b < 18; b++)
    begin
      pulse_ev(b);
      serve(3'h0, b < 5 ? 0 : b - 4);
      apb(1'b1, 8'h00, 32'h1 << b);
    end
    pulse_ev(5);
    pulse_ev(17);
    serve(3'h0, 13);
    apb(1'b1, 8'h00, 32'h20000);
    serve(3'h0, 1);
    apb(1'b1, 8'h00, 32'h20);
    irq_n <= 1'b0;
    cyc(3);
    serve(3'h0, 14);
    irq_n <= 1'b1;
    fi <= 1'b1;
    saw_i = 1'b0;
    serve(3'h4, 16);
    chk(saw_i, 33'h1);
    $display("test service done");
    lf = lfsr(lf);
    sp <= lf[15:0];
    apb(1'b1, 8'h0C, 32'h1);
    bound(3'h2);
    cyc(14);
    pulse_ev(17);
    cyc(5);
    @(negedge clk);
    chk({brd, baddr}, {1'b1, sp - 16'h0008});
    chk(run, 33'h0);
    chk(thalt, 33'h1);
    chk(orun, 33'h1);
    @(posedge clk);
    apb(1'b1, 8'h0C, 32'h0);
    @(negedge clk);
    chk(thalt, 33'h0);
    @(posedge clk);
    saw_x = 1'b0;
    q_vec.push_back(vexp(15));
    nmi_n <= 1'b0;
    wait_q;
    nmi_n <= 1'b1;
    chk(saw_x, 33'h1);
    cyc(4);
    apb(1'b1, 8'h00, 32'h20000);
    fi <= 1'b0;
    $display("test halt done");
    for (d = 0; d < 2; d++)
    begin
      apb(1'b1, 8'h08, d ? 32'h10 : 32'h0);
      bound(3'h1);
      cyc(12);
      @(negedge clk);
      chk({run, orun, crun}, 33'h0);
      @(posedge clk);
      pulse_ev(17);
      n = 0;
      for (k = 0; k < 5000 && crun !== 1'b1; k++)
      begin
        @(negedge clk);
        if (orun === 1'b1 && crun === 1'b0)
          n++;
      end
      if (crun !== 1'b1)
        tmo;
      chk(33'(n), d ? 33'd4000 : 33'd4);
      @(posedge clk);
      apb(1'b1, 8'h00, 32'h20000);
    end
    $display("test stop done");
    close_out;
  end
endmodule
